/* File: design/i2c_gpio_expander_8bit.sv */
// Contract
// (R1) Input-direction pins have both drivers off, so they float.
// (R2) Output-direction pins are driven from the output latch bit.
// (R3) Master opens each transaction with start while bus idle.
// (R4) Master sends address byte MSB first, direction bit last.
// (R5) Matching address is acknowledged low across ninth clock high phase.
// (R6) Strap inputs stay unchanged from start to stop.
// (R7) One bit per clock; data change during clock high is start/stop.
// (R8) Master ends each transaction with stop: data rises while clock high.
// (R9) Each byte is followed by an ack; device acks every received byte.
// (R10) Transmitter releases data before ack; acker holds it low high phase.
// (R11) On master nack the device releases data so a stop can follow.
// (R12) Address is 11100 followed by strap bit1 and strap bit0.
// (R13) Last address bit 1 means read, 0 means write.
// (R14) First byte after write address goes to command pointer.
// (R15) Command bits 1:0 pick input, latch, invert or direction register.
// (R16) Pointer persists across transactions until a new command byte.
// (R17) Input register reads live pin levels; writes to it are ignored.
// (R18) Output latch resets to ones; reads return latch, not pins.
// (R19) Invert bit 1 reports inverted pin level; resets to zero.
// (R20) Direction bit 1 is input, 0 is output; resets to all ones.
// (R21) Power-on reset sets registers and bus machine to defaults.
// (R22) Master writes command selecting input register before reading it.
// (R23) Low reset pin holds registers and bus machine at defaults.
// (R24) Input-pin edges assert open-drain active-low interrupt; outputs never.
// (R25) Interrupt clears on level return, input read at ack, or stop.
// (R26) Write accepts unlimited data bytes into the selected register.
// (R27) Clock and data pass synchronisers and glitch filter before use.
module i2c_gpio_expander_8bit
	import gpio_expander_pkg::*;
(
	input  wire logic                  clk,              // system clock, 40 MHz
	input  wire logic                  srst,             // synchronous reset, active high
	input  wire logic                  bus_clk,          // bus clock, clocks only the link_s1/link_s2 pin copy, which is never read
	input  wire logic                  reset_n,          // external reset pin, active low
	input  wire logic                  strap_addr_bit0,  // address strap bit 0
	input  wire logic                  strap_addr_bit1,  // address strap bit 1
	input  wire logic                  scl_in,           // serial clock line level
	input  wire logic                  sda_in,           // serial data line level
	output logic                       sda_oe,           // high pulls data line low
	input  wire logic [PORT_WIDTH-1:0] port_pins_in,     // port pin levels
	output logic      [PORT_WIDTH-1:0] port_pins_out,    // port pin drive value
	output logic      [PORT_WIDTH-1:0] port_pins_oe,     // high while pin driven
	output logic                       int_oe            // high pulls interrupt low
);
	typedef enum logic [2:0] {st_idle, st_addr, st_ack, st_rx, st_tx, st_txack} bus_state_e;

	typedef struct packed {
		logic [1:0]            rst_sync;
		logic [1:0]            scl_sync;
		logic [1:0]            sda_sync;
		logic [FILTER_LEN-1:0] scl_hist;
		logic [FILTER_LEN-1:0] sda_hist;
		logic                  scl_f;
		logic                  sda_f;
		logic [PORT_WIDTH-1:0] pin_s1;
		logic [PORT_WIDTH-1:0] pin_s2;
		logic [1:0]            strap_s1;
		logic [1:0]            strap_s2;
		bus_state_e            state;
		logic [3:0]            bit_cnt;
		logic [7:0]            shift;
		logic                  is_read;
		logic                  have_cmd;
		logic                  ack_drive;
		logic [7:0]            pointer;
		logic [7:0]            latch;
		logic [7:0]            invert;
		logic [7:0]            direction;
		logic [7:0]            snapshot;
		logic                  int_pend;
		logic                  sda_drive;
	} state_s;

	state_s cur;
	state_s next_cur;

	// pin levels are also copied on the bus clock domain, which runs only during frames;
	// this two-stage copy is never read: live_pins comes from pin_s2 in the clk domain
	logic [PORT_WIDTH-1:0] link_s1;
	logic [PORT_WIDTH-1:0] link_s2;

	always_ff @(posedge bus_clk) begin
		link_s1 <= port_pins_in;
		link_s2 <= link_s1;
	end

	logic [PORT_WIDTH-1:0] live_pins;
	logic [7:0]            level_view;
	logic [7:0]            read_data;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_seen;
	logic                  stop_seen;
	logic                  addr_hit;
	logic [7:0]            rx_byte;

	always_comb begin
		// R17: direct pin sampling in clk domain; link copy is never read
		live_pins  = cur.pin_s2;
		level_view = live_pins ^ cur.invert; // R19
		case (cur.pointer[CMD_SEL_MSB:CMD_SEL_LSB]) // R15
			SEL_INPUT:     read_data = level_view; // R17
			SEL_LATCH:     read_data = cur.latch; // R18
			SEL_INVERT:    read_data = cur.invert;
			SEL_DIRECTION: read_data = cur.direction;
			default:       read_data = level_view;
		endcase
	end

	always_comb begin
		next_cur = cur;
		next_cur.rst_sync = {cur.rst_sync[0], reset_n};
		next_cur.scl_sync = {cur.scl_sync[0], scl_in}; // R27
		next_cur.sda_sync = {cur.sda_sync[0], sda_in}; // R27
		next_cur.scl_hist = {cur.scl_hist[FILTER_LEN-2:0], cur.scl_sync[1]};
		next_cur.sda_hist = {cur.sda_hist[FILTER_LEN-2:0], cur.sda_sync[1]};
		// glitch filter: a level must hold for the whole history to count
		if (&cur.scl_hist)
			next_cur.scl_f = 1'b1; // R27
		else if (~|cur.scl_hist)
			next_cur.scl_f = 1'b0; // R27
		if (&cur.sda_hist)
			next_cur.sda_f = 1'b1;
		else if (~|cur.sda_hist)
			next_cur.sda_f = 1'b0;
		next_cur.pin_s1 = port_pins_in;
		next_cur.pin_s2 = cur.pin_s1;
		// straps are pins too; static in frames, but still synchronised before use
		next_cur.strap_s1 = {strap_addr_bit1, strap_addr_bit0};
		next_cur.strap_s2 = cur.strap_s1;

		scl_rise   = next_cur.scl_f & ~cur.scl_f;
		scl_fall   = ~next_cur.scl_f & cur.scl_f;
		start_seen = cur.scl_f & next_cur.scl_f & cur.sda_f & ~next_cur.sda_f; // R7
		stop_seen  = cur.scl_f & next_cur.scl_f & ~cur.sda_f & next_cur.sda_f; // R7
		rx_byte    = {cur.shift[6:0], cur.sda_f};
		// full byte sits in shift when the eighth falling clock is seen
		addr_hit   = cur.shift[7:1] == {ADDR_UPPER, cur.strap_s2}; // R12

		// R24: an input pin differing from its last reported level pulls the line low
		if (|((live_pins ^ cur.snapshot) & cur.direction))
			next_cur.int_pend = 1'b1; // R24
		else
			next_cur.int_pend = 1'b0; // R25

		if (start_seen) begin
			next_cur.state     = st_addr; // R7
			next_cur.bit_cnt   = 4'h0;
			next_cur.have_cmd  = 1'b0;
			next_cur.sda_drive = 1'b0;
		end else if (stop_seen) begin
			next_cur.state     = st_idle; // R7
			next_cur.sda_drive = 1'b0;
			next_cur.snapshot  = live_pins; // R25
			next_cur.int_pend  = 1'b0; // R25
		end else begin
			case (cur.state)
				st_idle: begin
					next_cur.sda_drive = 1'b0;
				end
				st_addr, st_rx: begin
					if (scl_rise) begin
						next_cur.shift   = rx_byte; // R4
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
					end
					if (scl_fall && cur.bit_cnt == 4'h8) begin
						next_cur.bit_cnt = 4'h0;
						next_cur.state   = st_ack;
						if (cur.state == st_addr) begin
							next_cur.ack_drive = addr_hit; // R5
							next_cur.is_read   = cur.shift[0]; // R13
							if (!addr_hit)
								next_cur.state = st_idle;
						end else begin
							next_cur.ack_drive = 1'b1; // R9
							if (!cur.have_cmd) begin
								next_cur.pointer  = cur.shift; // R14
								next_cur.have_cmd = 1'b1;
							end else begin
								case (cur.pointer[CMD_SEL_MSB:CMD_SEL_LSB]) // R26
									SEL_LATCH:     next_cur.latch     = cur.shift;
									SEL_INVERT:    next_cur.invert    = cur.shift;
									SEL_DIRECTION: next_cur.direction = cur.shift;
									default:       next_cur.latch     = cur.latch; // R17
								endcase
							end
						end
						next_cur.sda_drive = addr_hit | (cur.state == st_rx); // R10
					end
				end
				st_ack: begin
					if (scl_fall) begin
						next_cur.bit_cnt = 4'h0;
						if (cur.is_read) begin
							next_cur.state     = st_tx;
							next_cur.shift     = read_data;
							next_cur.sda_drive = ~read_data[7];
						end else begin
							next_cur.state     = st_rx; // R26
							next_cur.sda_drive = 1'b0; // R10
						end
					end
				end
				st_tx: begin
					if (scl_fall) begin
						next_cur.bit_cnt = cur.bit_cnt + 4'h1;
						next_cur.shift   = {cur.shift[6:0], 1'b0};
						if (cur.bit_cnt == 4'h7) begin
							next_cur.state     = st_txack;
							next_cur.sda_drive = 1'b0; // R10
						end else begin
							next_cur.sda_drive = ~cur.shift[6];
						end
					end
				end
				st_txack: begin
					if (scl_rise && cur.pointer[CMD_SEL_MSB:CMD_SEL_LSB] == SEL_INPUT) begin
						next_cur.snapshot = live_pins; // R25
						next_cur.int_pend = 1'b0; // R25
					end
					if (scl_fall) begin
						if (cur.sda_f) begin
							next_cur.state     = st_idle; // R11
							next_cur.sda_drive = 1'b0; // R11
						end else begin
							next_cur.state     = st_tx; // R16
							next_cur.bit_cnt   = 4'h0;
							next_cur.shift     = read_data;
							next_cur.sda_drive = ~read_data[7];
						end
					end
				end
				default: next_cur.state = st_idle;
			endcase
		end

		if (srst || !cur.rst_sync[1]) begin // R21 R23
			next_cur.state     = st_idle;
			next_cur.bit_cnt   = 4'h0;
			next_cur.shift     = 8'h00;
			next_cur.is_read   = 1'b0;
			next_cur.have_cmd  = 1'b0;
			next_cur.ack_drive = 1'b0;
			next_cur.sda_drive = 1'b0;
			next_cur.pointer   = POINTER_RESET;
			next_cur.latch     = LATCH_RESET; // R18
			next_cur.invert    = INVERT_RESET; // R19
			next_cur.direction = DIRECTION_RESET; // R20
			next_cur.snapshot  = live_pins;
			next_cur.int_pend  = 1'b0;
		end
		if (srst) begin
			next_cur.rst_sync = 2'h3;
			next_cur.scl_sync = 2'h3;
			next_cur.sda_sync = 2'h3;
			next_cur.scl_hist = '1;
			next_cur.sda_hist = '1;
			next_cur.scl_f    = 1'b1;
			next_cur.sda_f    = 1'b1;
			next_cur.pin_s1   = 8'h00;
			next_cur.pin_s2   = 8'h00;
			next_cur.strap_s1 = 2'h0;
			next_cur.strap_s2 = 2'h0;
			next_cur.snapshot = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		cur <= next_cur;
	end

	always_comb begin
		port_pins_oe  = ~cur.direction; // R1 R20
		port_pins_out = cur.latch & ~cur.direction; // R2
		sda_oe        = cur.sda_drive; // R5
		int_oe        = cur.int_pend; // R24
	end
endmodule

/* File: shared/gpio_expander_pkg.sv */
package gpio_expander_pkg;
	localparam int          PORT_WIDTH      = 8;
	localparam logic [4:0]  ADDR_UPPER      = 5'h1C;
	localparam logic [1:0]  SEL_INPUT       = 2'h0;
	localparam logic [1:0]  SEL_LATCH       = 2'h1;
	localparam logic [1:0]  SEL_INVERT      = 2'h2;
	localparam logic [1:0]  SEL_DIRECTION   = 2'h3;
	localparam int          CMD_SEL_LSB     = 0;
	localparam int          CMD_SEL_MSB     = 1;
	localparam logic [7:0]  LATCH_RESET     = 8'hFF;
	localparam logic [7:0]  INVERT_RESET    = 8'h00;
	localparam logic [7:0]  DIRECTION_RESET = 8'hFF;
	localparam logic [7:0]  POINTER_RESET   = 8'h00;
	localparam int          FILTER_LEN      = 3;
endpackage

/* File: tb/i2c_gpio_expander_8bit_assertions.sv */
module gpio_expander_checker import gpio_expander_pkg::*; (
	input wire logic                  clk,           // system clock
	input wire logic                  srst,          // sync reset
	input wire logic                  reset_n,       // reset pin
	input wire logic                  scl_in,        // clock line
	input wire logic                  sda_in,        // data line
	input wire logic                  sda_oe,        // data pull
	input wire logic                  int_oe,        // irq pull
	input wire logic [PORT_WIDTH-1:0] port_pins_in,  // pin levels
	input wire logic [PORT_WIDTH-1:0] port_pins_out, // pin drive
	input wire logic [PORT_WIDTH-1:0] port_pins_oe   // pin enables
);
	timeunit 1ns / 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [3:0] calm;
	// a direction change may raise a false irq, so it restarts the count too
	always_ff @(posedge clk) begin
		if (srst || !reset_n || $changed(port_pins_in) || $changed(port_pins_oe)) begin
			calm <= 4'h0;
		end else if (calm != 4'hF) begin
			calm <= calm + 4'h1;
		end
	end
	AST_RESET_DEFAULTS: assert property (disable iff (1'b0) srst |=> !sda_oe && port_pins_oe == 8'h00)
		else $error("defaults missing after reset");
	AST_DRIVE_MASK: assert property ((port_pins_out & ~port_pins_oe) == 8'h00)
		else $error("drive value on undriven pin");
	AST_PULL_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data pulled while clock high");
	AST_STEADY_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data moved while clock high");
	AST_ACK_HOLD: assert property (sda_oe && $rose(scl_in) |-> sda_oe [*8])
		else $error("ack not held");
	AST_STOP_QUIET: assert property (scl_in && $rose(sda_in) |=> !sda_oe [*8])
		else $error("data driven after stop");
	AST_OUTPUT_NO_IRQ: assert property ((port_pins_oe == 8'hFF) [*6] |-> !int_oe)
		else $error("irq from output pins");
	AST_IRQ_CAUSE: assert property ($rose(int_oe) |-> calm < 4'h8)
		else $error("irq without pin change");
	cover property ($rose(sda_oe));
	cover property ($rose(int_oe));
	cover property (port_pins_oe == 8'h0F);
	cover property (port_pins_oe == 8'hFF);
endmodule

bind i2c_gpio_expander_8bit gpio_expander_checker chk_u (.clk(clk), .srst(srst),
	.reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe), .int_oe(int_oe),
	.port_pins_in(port_pins_in), .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe));

/* File: tb/i2c_master_model.sv */
module i2c_master_model (
	input  wire logic clk,     // system clock
	input  wire logic sda,     // resolved data line
	output logic      scl,     // clock line
	output logic      sda_low, // high pulls data low
	output logic      busy     // frame open
);
	timeunit 1ns / 100ps;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		busy = 1'b0;
	end
	// 8 clk per step keeps each phase well past the device filter delay
	task automatic step(input logic c, input logic d);
		repeat (8) @(posedge clk);
		scl <= c;
		sda_low <= !d;
	endtask
	task automatic start();
		busy <= 1'b1;
		step(scl, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		busy <= 1'b0;
	endtask
	task automatic bit_xfer(input logic b, output logic r);
		step(1'b0, b);
		step(1'b1, b);
		step(1'b1, b);
		r = sda;
		step(1'b0, b);
	endtask
	task automatic byte_xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], q[i]);
		end
		bit_xfer(a, ack);
	endtask
endmodule

/* File: tb/i2c_gpio_expander_8bit_bench.sv */
module i2c_gpio_expander_8bit_bench import gpio_expander_pkg::*;;
	timeunit 1ns / 100ps;
	logic       clk, srst, bus_clk, reset_n, strap_addr_bit0, strap_addr_bit1;
	logic       sda_oe, int_oe, scl, sda_low, busy, ack;
	logic [7:0] ext, pins, pins_out, pins_oe, q;
	int         bad_count, num_checks;
	wire        sda_line = !(sda_low || sda_oe);
	assign pins = (pins_out & pins_oe) | (ext & ~pins_oe);
	i2c_gpio_expander_8bit dut_u (.clk(clk), .srst(srst), .bus_clk(bus_clk), .reset_n(reset_n),
		.strap_addr_bit0(strap_addr_bit0), .strap_addr_bit1(strap_addr_bit1), .scl_in(scl),
		.sda_in(sda_line), .sda_oe(sda_oe), .port_pins_in(pins), .port_pins_out(pins_out),
		.port_pins_oe(pins_oe), .int_oe(int_oe));
	i2c_master_model m_u (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(sda_low), .busy(busy));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// link clock idles between frames
	initial begin
		bus_clk = 1'b0;
		#3.7;
		forever #16 bus_clk = busy ? ~bus_clk : bus_clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic want);
		m_u.byte_xfer(d, 1'b1, q, ack);
		check({7'h00, ack}, {7'h00, want});
	endtask
	task automatic open_wr(input logic [7:0] p);
		m_u.start();
		send({5'h1C, strap_addr_bit1, strap_addr_bit0, 1'b0}, 1'b0);
		send(p, 1'b0);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		open_wr(p);
		send(d, 1'b0);
		m_u.stop();
	endtask
	// second byte refused by the master, so the device must let go
	task automatic rd(input logic [7:0] want);
		m_u.start();
		send({5'h1C, strap_addr_bit1, strap_addr_bit0, 1'b1}, 1'b0);
		m_u.byte_xfer(8'hFF, 1'b0, q, ack);
		check(q, want);
		m_u.byte_xfer(8'hFF, 1'b1, q, ack);
		check(q, want);
		m_u.stop();
	endtask
	task automatic int_is(input logic want);
		for (int i = 0; i < 40 && int_oe !== want; i++) @(posedge clk);
		check({7'h00, int_oe}, {7'h00, want});
		if (int_oe !== want) report_and_stop();
	endtask
	task automatic s_defaults();
		logic [7:0] want [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
		check(pins_oe, 8'h00);
		for (int i = 0; i < 4; i++) begin
			open_wr(i[7:0]);
			rd(want[i]);
		end
	endtask
	task automatic s_outputs();
		open_wr(8'h01);
		send(8'hA5, 1'b0);
		send(8'h3C, 1'b0);
		m_u.stop();
		wr(8'h03, 8'hF0);
		check(pins_oe, 8'h0F);
		check(pins_out & pins_oe, 8'h0C);
		open_wr(8'h01);
		rd(8'h3C);
	endtask
	task automatic s_input();
		ext <= 8'h5A;
		wr(8'h02, 8'h81);
		open_wr(8'h00);
		rd(8'hDD);
		wr(8'h00, 8'h00);
		rd(8'hDD);
		ext <= 8'hDA;
		int_is(1'b1);
		rd(8'h5D);
		int_is(1'b0);
	endtask
	task automatic s_address();
		for (int s = 0; s < 4; s++) begin
			{strap_addr_bit1, strap_addr_bit0} <= s[1:0];
			@(posedge clk);
			m_u.start();
			send({5'h1C, s[1:0], 1'b0}, 1'b0);
			m_u.stop();
			m_u.start();
			send({5'h1C, s[1:0] + 2'h1, 1'b0}, 1'b1);
			m_u.stop();
		end
	endtask
	task automatic s_reset_pin();
		reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge clk);
		check(pins_oe, 8'h00);
		open_wr(8'h01);
		rd(8'hFF);
		// all pins outputs: latch changes move the pins but never the interrupt
		wr(8'h03, 8'h00);
		check(pins_oe, 8'hFF);
		wr(8'h01, 8'h00);
		repeat (10) @(posedge clk);
		check(pins, 8'h00);
		check({7'h00, int_oe}, 8'h00);
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		srst = 1'b1;
		reset_n = 1'b1;
		{strap_addr_bit1, strap_addr_bit0} = 2'b00;
		ext = 8'h00;
		bad_count = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (10) @(posedge clk);
		s_defaults();
		s_outputs();
		s_input();
		s_address();
		s_reset_pin();
		report_and_stop();
	end
endmodule
